// *** shared/dccfg_map.vh ***
// Purpose: Field positions, addresses and reset values of the converter SFRs
// Assumes: 8-bit SFR bus with a page register outside this block
// Notes: Definitions only
`ifndef DCCFG_MAP_VH
`define DCCFG_MAP_VH

`define DCCFG_CFG_PAGE 4'h0
`define DCCFG_CFG_ADDR 8'h96
`define DCCFG_MODE_PAGE 4'hf
`define DCCFG_MODE_ADDR 8'h94
`define DCCFG_CFG_RESET 8'h00
`define DCCFG_MODE_RESET 3'h0

`define DCCFG_LP_BIT 7
`define DCCFG_DIV_HI 6
`define DCCFG_DIV_LO 5
`define DCCFG_SARPOL_BIT 4
`define DCCFG_INV_BIT 3
`define DCCFG_ILIM_BIT 2
`define DCCFG_SLP_BIT 1
`define DCCFG_SRC_BIT 0

`define DCCFG_BYPIND_BIT 3
`define DCCFG_BYPSEL_HI 2
`define DCCFG_BYPSEL_LO 1
`define DCCFG_PASD_BIT 0

`define DCCFG_BYP_OFF 2'h0
`define DCCFG_BYP_AUTO_OSC 2'h1
`define DCCFG_BYP_AUTO_LOW 2'h2
`define DCCFG_BYP_FORCE 2'h3

`define DCCFG_DIVMAX 3'h7
`endif

// *** test/dccfg_regs_props.sv ***
// Purpose: Port checks of the converter SFR block
// Assumes: Writes to one register are spaced by two cycles or more
// Notes: Bound to every dccfg_regs
`timescale 1ns/10ps
`default_nettype none
module dccfg_regs_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// SFR bus
	input wire logic [3:0] sfr_page_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	// Converter side
	input wire logic adc_sync_enable_i,
	input wire logic low_power_enable_o,
	input wire logic passive_diode_enable_o,
	input wire logic bypass_allow_o,
	input wire logic bypass_force_o,
	input wire logic osc_run_in_bypass_o,
	input wire logic adc_track_allow_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic cfg_sel;
	logic mode_sel;
	assign cfg_sel = sfr_page_i == 4'h0 && sfr_addr_i == 8'h96;
	assign mode_sel = sfr_page_i == 4'hf && sfr_addr_i == 8'h94;
	property p_hit; (sfr_wr_i || sfr_rd_i) && (cfg_sel || mode_sel) |=> sfr_hit_o; endproperty
	a_hit: assert property (p_hit) else $error("no hit");
	property p_unmapped; (sfr_wr_i || sfr_rd_i) && !cfg_sel && !mode_sel |=> !sfr_hit_o && sfr_rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped answered");
	property p_rdata_idle; !sfr_rd_i |=> sfr_rdata_o == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
	property p_mode_hi; sfr_rd_i && mode_sel |=> sfr_rdata_o[7:4] == 4'h0; endproperty
	a_mode_hi: assert property (p_mode_hi) else $error("mode high bits set");
	property p_lp; sfr_wr_i && cfg_sel |-> ##2 low_power_enable_o == $past(sfr_wdata_i[7], 2); endproperty
	a_lp: assert property (p_lp) else $error("low power field");
	property p_pasd; sfr_wr_i && mode_sel |-> ##2 passive_diode_enable_o == $past(sfr_wdata_i[0], 2); endproperty
	a_pasd: assert property (p_pasd) else $error("diode field");
	property p_force; bypass_force_o |-> bypass_allow_o && !osc_run_in_bypass_o; endproperty
	a_force: assert property (p_force) else $error("force decode");
	property p_off; !bypass_allow_o |-> osc_run_in_bypass_o && !bypass_force_o; endproperty
	a_off: assert property (p_off) else $error("off decode");
	property p_track; !adc_sync_enable_i |=> adc_track_allow_o; endproperty
	a_track: assert property (p_track) else $error("track blocked");
	c_force: cover property (bypass_force_o);
	c_read: cover property (sfr_rd_i && mode_sel);
	c_sync: cover property (adc_sync_enable_i && !adc_track_allow_o);
endmodule
bind dccfg_regs dccfg_regs_props u_props (.*);
`default_nettype wire

// *** test/tb.sv ***
// Purpose: Directed bench of the converter SFR block
// Assumes: Inputs change on the falling edge
// Notes: Tick counts allow one tick of phase slack
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i = 0, resetn_i = 0, wr = 0, rd = 0, sync = 0, byp = 0;
	logic osc = 0, quiet = 0, hit, lp, thr, slp, pasd, al, fo, orun;
	logic tick, sar, track, s0;
	logic [3:0] page = 4'h0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
	int mismatches = 0, comparisons = 0, n, l0, l1;
	always #5 clk_i = ~clk_i;
	dccfg_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_page_i(page),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd),
		.sfr_rdata_o(rdat), .sfr_hit_o(hit), .adc_sync_enable_i(sync),
		.bypass_active_i(byp), .local_osc_tick_i(osc),
		.quiet_interval_i(quiet), .low_power_enable_o(lp),
		.peak_current_threshold_o(thr), .sleep_supply_connect_o(slp),
		.passive_diode_enable_o(pasd), .bypass_allow_o(al),
		.bypass_force_o(fo), .osc_run_in_bypass_o(orun),
		.converter_clock_tick_o(tick), .sar_clock_o(sar),
		.adc_track_allow_o(track));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wait_n(input int c);
		repeat (c) @(negedge clk_i);
	endtask
	task acc(input logic w, input logic [3:0] p, input logic [7:0] a,
		input logic [7:0] d);
		page = p;
		addr = a;
		wd = d;
		wr = w;
		rd = !w;
		wait_n(1);
		wr = 0;
		rd = 0;
	endtask
	task rdchk(input logic [3:0] p, input logic [7:0] a, input logic [7:0] e);
		acc(0, p, a, 8'h00);
		chk(rdat, e);
		chk({7'h00, hit}, {7'h00, (p == 4'h0 && a == 8'h96) ||
			(p == 4'hf && a == 8'h94)});
		wait_n(1);
	endtask
	task t_reset;
		rdchk(4'h0, 8'h96, 8'h00);
		rdchk(4'hf, 8'h94, 8'h00);
		chk({lp, thr, slp, pasd, al, fo, orun}, 8'h01);
	endtask
	task t_cfg;
		acc(1, 4'h0, 8'h96, 8'h86);
		wait_n(2);
		rdchk(4'h0, 8'h96, 8'h86);
		chk({lp, thr, slp}, 8'h07);
		acc(1, 4'h0, 8'h96, 8'h7e);
		wait_n(2);
		rdchk(4'h0, 8'h96, 8'h7e);
		chk({lp, thr, slp}, 8'h03);
	endtask
	task t_mode;
		for (int c = 0; c < 4; c++) begin
			acc(1, 4'hf, 8'h94, {4'hf, 1'b1, c[1:0], 1'b1});
			wait_n(2);
			rdchk(4'hf, 8'h94, {5'h00, c[1:0], 1'b1});
			chk({al, fo, orun, pasd}, {c != 0, c == 3, c < 2, 1'b1});
		end
	endtask
	task t_unmapped;
		rdchk(4'h0, 8'h94, 8'h00);
		acc(1, 4'hf, 8'h96, 8'hff);
		wait_n(2);
		rdchk(4'h0, 8'h96, 8'h7e);
	endtask
	task t_bypind;
		byp = 1;
		wait_n(4);
		rdchk(4'hf, 8'h94, 8'h0f);
		byp = 0;
	endtask
	task t_div(input logic [1:0] c, input logic src, input int e);
		acc(1, 4'h0, 8'h96, {1'b0, c, 4'h0, src});
		wait_n(12);
		n = 0;
		for (int i = 0; i < 80; i++) begin
			wait_n(1);
			n += tick;
		end
		comparisons++;
		if (n < e - 1 || n > e + 1) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, n, e);
		end
	endtask
	task t_sync;
		sync = 1;
		wait_n(5);
		chk({7'h00, track}, 8'h00);
		quiet = 1;
		wait_n(5);
		chk({7'h00, track}, 8'h01);
		quiet = 0;
		sync = 0;
		wait_n(3);
		chk({7'h00, track}, 8'h01);
	endtask
	task t_local;
		acc(1, 4'h0, 8'h96, 8'h20);
		wait_n(4);
		n = 0;
		for (int i = 0; i < 80; i++) begin
			osc = (i % 4 == 0);
			wait_n(1);
			n += tick;
		end
		osc = 0;
		comparisons++;
		if (n < 19 || n > 21) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, n, 20);
		end
	endtask
	task t_sar;
		wait_n(4);
		s0 = sar;
		sync = 1;
		wait_n(2);
		chk({7'h00, sar}, {7'h00, ~s0});
		acc(1, 4'h0, 8'h96, 8'h10);
		wait_n(2);
		chk({7'h00, sar}, {7'h00, s0});
		sync = 0;
		wait_n(2);
		chk({7'h00, sar}, {7'h00, s0});
		acc(1, 4'h0, 8'h96, 8'h00);
		wait_n(2);
		chk({7'h00, sar}, {7'h00, s0});
	endtask
	task t_inv(input logic v, output int lat);
		acc(1, 4'h0, 8'h96, {1'b0, 2'h3, 1'b0, v, 3'h0});
		wait_n(4);
		acc(1, 4'h0, 8'h96, {1'b0, 2'h3, 1'b0, v, 3'h1});
		lat = 0;
		while (lat < 30 && tick !== 1'b1) begin
			wait_n(1);
			lat++;
		end
	endtask
	task t_invert;
		t_inv(1'b0, l0);
		t_inv(1'b1, l1);
		comparisons++;
		if (l0 >= 30 || l1 != l0 + 1) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, l1, l0 + 1);
		end
	endtask
	task print_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		wait_n(6);
		resetn_i = 1;
		wait_n(1);
		t_reset();
		t_cfg();
		t_mode();
		t_unmapped();
		t_bypind();
		t_div(2'h0, 1, 80);
		t_div(2'h1, 1, 40);
		t_div(2'h2, 1, 40);
		t_div(2'h3, 1, 10);
		t_div(2'h3, 0, 0);
		t_local();
		t_sar();
		t_invert();
		t_sync();
		print_verdict();
	end
endmodule
`default_nettype wire

// *** verilog/dccfg_clkdiv.v ***
// Purpose: Converter clock enable from the system clock, by 1, 2 or 8
// Assumes: One clock; the divided rate is an enable pulse
// Notes: Ratio change waits for the current period to end
`timescale 1ns/10ps
`default_nettype none
`include "dccfg_map.vh"

module dccfg_clkdiv (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Control
	input wire run_i,
	input wire [1:0] div_code_i,
	// Enable
	output reg tick_o
);

	reg [2:0] count;
	reg [2:0] limit;

	function [2:0] dccfg_limit;
		input [1:0] code;
		begin
			case (code)
			2'h0: dccfg_limit = 3'h0;
			2'h1: dccfg_limit = 3'h1;
			2'h2: dccfg_limit = 3'h1;
			default: dccfg_limit = `DCCFG_DIVMAX;
			endcase
		end
	endfunction

	// New ratio is taken at a period end or while stopped, so no runt periods
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count <= 3'h0;
			limit <= 3'h0;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			count <= 3'h0;
			limit <= dccfg_limit(div_code_i);
			tick_o <= 1'b0;
		end else if (count >= limit) begin
			count <= 3'h0;
			limit <= dccfg_limit(div_code_i);
			tick_o <= 1'b1;
		end else begin
			count <= count + 3'h1;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** verilog/dccfg_regs.v ***
// Purpose: Converter configuration and mode SFRs, converter clock steering
// Assumes: SFR bus on clk_i; analog status arrives asynchronously
// Notes: Sync enable comes from the control register outside this block
//
// What this block does
// - Configuration bit 7 enables converter low-power mode; resets to zero.
// - Divide field: 00 by one, 01 by two, 10 by two, 11 by eight.
// - Divide field ignored while the local oscillator is the source.
// - With sync on, SAR polarity bit 0 inverts the SAR clock, 1 not.
// - SAR polarity bit ignored when ADC synchronisation is off.
// - Bit 3 set inverts system clock into the converter divider.
// - Bit 2 selects one of two peak current limit thresholds.
// - Bit 1 sets sleep supply: 0 rail to battery, 1 floating.
// - Bit 0 picks clock source: 0 local oscillator, 1 system clock.
// - Configuration register at page 0x0, address 0x96, all RW, reset 0.
// - Mode register at page 0xF, address 0x94; writable fields reset 0.
// - Mode bits 7 to 4 read zero, writes ignored.
// - Mode bit 3 is read-only bypass indicator from converter state.
// - Bypass select 00 keeps bypass disabled, converter regulating.
// - Bypass select 01 auto bypass with oscillator running.
// - Bypass select 11 forces bypass unconditionally.
// - Mode bit 0 enables passive diode operation; resets to 0.
// - With sync on, ADC tracking and SAR clock follow switching cycle.
`timescale 1ns/10ps
`default_nettype none
`include "dccfg_map.vh"

module dccfg_regs (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// SFR bus
	input wire [3:0] sfr_page_i,
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire [7:0] sfr_wdata_i,
	output reg [7:0] sfr_rdata_o,
	output reg sfr_hit_o,
	// From converter control register and analog side
	input wire adc_sync_enable_i,
	input wire bypass_active_i,
	input wire local_osc_tick_i,
	input wire quiet_interval_i,
	// Converter controls
	output reg low_power_enable_o,
	output reg peak_current_threshold_o,
	output reg sleep_supply_connect_o,
	output reg passive_diode_enable_o,
	output reg bypass_allow_o,
	output reg bypass_force_o,
	output reg osc_run_in_bypass_o,
	// Converter and SAR clocks as enables
	output reg converter_clock_tick_o,
	output reg sar_clock_o,
	output reg adc_track_allow_o
);

	reg [7:0] converter_configuration;
	reg [1:0] bypass_select;
	reg passive_diode_enable;
	reg conv_phase;
	reg src_sys;
	reg src_switching;
	wire bypass_indicator;
	wire quiet_sync;
	wire local_sync;
	wire div_tick;
	wire cfg_hit;
	wire mode_hit;
	wire [7:0] converter_mode;
	wire sar_pol;
	reg next_phase;
	reg next_tick;
	reg div_tick_late;
	reg inv_active;
	wire inv_sel;

	assign cfg_hit = (sfr_page_i == `DCCFG_CFG_PAGE) &&
		(sfr_addr_i == `DCCFG_CFG_ADDR);
	assign mode_hit = (sfr_page_i == `DCCFG_MODE_PAGE) &&
		(sfr_addr_i == `DCCFG_MODE_ADDR);
	// Upper nibble tied low
	assign converter_mode = {4'h0, bypass_indicator, bypass_select,
		passive_diode_enable};
	assign sar_pol = converter_configuration[`DCCFG_SARPOL_BIT];
	assign inv_sel = converter_configuration[`DCCFG_INV_BIT];

	// Analog status crosses in through two flops
	dccfg_sync2 u_byp_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i(bypass_active_i),
		.q_o(bypass_indicator)
	);

	dccfg_sync2 u_quiet_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i(quiet_interval_i),
		.q_o(quiet_sync)
	);

	dccfg_sync2 u_osc_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i(local_osc_tick_i),
		.q_o(local_sync)
	);

	// Divider runs only on the system clock source
	dccfg_clkdiv u_div (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(src_sys),
		.div_code_i(converter_configuration[`DCCFG_DIV_HI:`DCCFG_DIV_LO]),
		.tick_o(div_tick)
	);

	// Register writes take effect at the write edge
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			converter_configuration <= `DCCFG_CFG_RESET;
			{bypass_select, passive_diode_enable} <=
				`DCCFG_MODE_RESET;
		end else if (sfr_wr_i) begin
			if (cfg_hit)
				converter_configuration <= sfr_wdata_i;
			if (mode_hit) begin
				bypass_select <= sfr_wdata_i[`DCCFG_BYPSEL_HI:`DCCFG_BYPSEL_LO];
				passive_diode_enable <= sfr_wdata_i[`DCCFG_PASD_BIT];
			end
		end
	end

	// Read data
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sfr_rdata_o <= 8'h00;
			sfr_hit_o <= 1'b0;
		end else begin
			sfr_hit_o <= (sfr_rd_i || sfr_wr_i) && (cfg_hit || mode_hit);
			if (sfr_rd_i && cfg_hit)
				sfr_rdata_o <= converter_configuration;
			else if (sfr_rd_i && mode_hit)
				sfr_rdata_o <= converter_mode;
			else
				sfr_rdata_o <= 8'h00;
		end
	end

	// Source switch waits one idle cycle so no runt enable escapes
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_sys <= 1'b0;
			src_switching <= 1'b0;
		end else if (src_switching) begin
			src_sys <= converter_configuration[`DCCFG_SRC_BIT];
			src_switching <= 1'b0;
		end else if (src_sys != converter_configuration[`DCCFG_SRC_BIT]) begin
			src_switching <= 1'b1;
		end
	end

	// Converter clock phase; inversion swaps the active half
	always @* begin
		next_tick = 1'b0;
		next_phase = conv_phase;
		if (!src_switching) begin
			if (src_sys)
				next_tick = inv_active ? div_tick_late : div_tick;
			else
				next_tick = local_sync;
		end
		if (next_tick)
			next_phase = ~conv_phase;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			conv_phase <= 1'b0;
			converter_clock_tick_o <= 1'b0;
			sar_clock_o <= 1'b0;
			adc_track_allow_o <= 1'b0;
		end else begin
			conv_phase <= next_phase;
			converter_clock_tick_o <= next_tick;
			if (adc_sync_enable_i) begin
				// Polarity bit low inverts the SAR clock
				sar_clock_o <= sar_pol ? next_phase : ~next_phase;
				adc_track_allow_o <= quiet_sync;
			end else begin
				sar_clock_o <= next_phase;
				adc_track_allow_o <= 1'b1;
			end
		end
	end

	// Field copies and bypass decode
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_power_enable_o <= 1'b0;
			peak_current_threshold_o <= 1'b0;
			sleep_supply_connect_o <= 1'b0;
			passive_diode_enable_o <= 1'b0;
			bypass_allow_o <= 1'b0;
			bypass_force_o <= 1'b0;
			osc_run_in_bypass_o <= 1'b1;
		end else begin
			low_power_enable_o <= converter_configuration[`DCCFG_LP_BIT];
			peak_current_threshold_o <=
				converter_configuration[`DCCFG_ILIM_BIT];
			sleep_supply_connect_o <=
				converter_configuration[`DCCFG_SLP_BIT];
			passive_diode_enable_o <= passive_diode_enable;
			case (bypass_select)
			`DCCFG_BYP_OFF: begin
				bypass_allow_o <= 1'b0;
				bypass_force_o <= 1'b0;
				osc_run_in_bypass_o <= 1'b1;
			end
			`DCCFG_BYP_AUTO_OSC: begin
				bypass_allow_o <= 1'b1;
				bypass_force_o <= 1'b0;
				osc_run_in_bypass_o <= 1'b1;
			end
			`DCCFG_BYP_AUTO_LOW: begin
				bypass_allow_o <= 1'b1;
				bypass_force_o <= 1'b0;
				osc_run_in_bypass_o <= 1'b0;
			end
			default: begin
				bypass_allow_o <= 1'b1;
				bypass_force_o <= 1'b1;
				osc_run_in_bypass_o <= 1'b0;
			end
			endcase
		end
	end

	// Inverted divider input lands ticks half a cycle late, rounded to one
	// New setting taken at once off the system clock, else only on a cycle where div_tick_late differs from it
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_tick_late <= 1'b0;
			inv_active <= 1'b0;
		end else begin
			div_tick_late <= div_tick;
			if (!src_sys || (inv_sel ? !div_tick_late : div_tick_late))
				inv_active <= inv_sel;
		end
	end

endmodule
`default_nettype wire

// *** verilog/dccfg_sync2.v ***
// Purpose: Two-flop synchroniser for a level
// Assumes: Input is asynchronous to clk_i
// Notes: First stage read only by the second
`timescale 1ns/10ps
`default_nettype none

module dccfg_sync2 (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Level
	input wire d_i,
	output reg q_o
);

	reg meta;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule
`default_nettype wire
